// [shared/tkc_defs.vh]
`ifndef TKC_DEFS_VH
`define TKC_DEFS_VH

// ---------------------------------------------------------------------------
// register word indexes (byte address = index * 4)
// ---------------------------------------------------------------------------
`define TKC_IDX_CFG 16'hA130
`define TKC_IDX_AFG 16'hA131
`define TKC_IDX_FFG 16'hA132
`define TKC_IDX_TH0 16'hA133
`define TKC_IDX_TH1 16'hA134
`define TKC_IDX_TH2 16'hA135
`define TKC_IDX_TMR 16'hA140
`define TKC_IDX_VAL 16'hA144
`define TKC_IDX_MVF 16'hA148
`define TKC_IDX_MVS 16'hA14C
`define TKC_IDX_WAKE 16'hA150

// ---------------------------------------------------------------------------
// config register fields
// ---------------------------------------------------------------------------
`define TKC_CFG_EN 7
`define TKC_CFG_MODE 6
`define TKC_CFG_CKS_HI 5
`define TKC_CFG_CKS_LO 4
`define TKC_CFG_AUTO 3
`define TKC_CFG_IEN 2
`define TKC_CFG_IFLAG 1
`define TKC_CFG_START 0
`define TKC_AFG_HIGH_SPEED_SEL 7
`define TKC_TH2_ABS 7
`define TKC_DLY_HI 6
`define TKC_DLY_LO 5
`define TKC_THR_HI 4
`define TKC_SLOW_HI 7
`define TKC_SLOW_LO 4
`define TKC_FAST_HI 3
`define TKC_CFG_RESET 8'h00

// ---------------------------------------------------------------------------
// clock select codes and misc
// ---------------------------------------------------------------------------
`define TKC_CKS_FAST_INTERNAL_OSC 2'h0
`define TKC_CKS_PLL 2'h1
`define TKC_CKS_RTC 2'h2
`define TKC_CKS_SLOW_INTERNAL_OSC 2'h3
`define TKC_RATIO_SHIFT 10
`define TKC_DLY_CNT0 11'h040
`define TKC_DLY_CNT1 11'h100
`define TKC_DLY_CNT2 11'h200
`define TKC_DLY_CNT3 11'h400
`define TKC_AUTO_MASK 24'h00FFFF
`define TKC_RESP_OKAY 2'h0
`define TKC_RESP_SLVERR 2'h2

`endif

// [src/tkc_touch_ctrl.v]
// Behaviour
// RULE1: one 24-bit timer and one 24-bit counter
// RULE2: mode 0: sense clock times, internal counts
// RULE3: mode 1: internal clock times, sense counts
// RULE4: clock select picks main clock of four
// RULE5: start clears counter, loads timer, runs both
// RULE6: counter adds one per assigned clock edge
// RULE7: timer expiry captures count, raises interrupt
// RULE8: each capture updates fast and slow filters
// RULE9: software preloads previous averages before start
// RULE10: auto mode repeats captures without interrupt
// RULE11: auto mode limits values to 16 bits
// RULE12: auto wake when fast exceeds slow by threshold
// RULE13: start one: single or continuous capture
// RULE14: start zero aborts capture in progress
// RULE15: bit 0 reads busy, writes start
// RULE16: config register bit layout fixed
// RULE17: analog high speed bit in bit 7
// RULE18: keeps running in sleep from slow oscillator
// RULE19: fast and slow filter weight settings
// RULE20: absolute or ratio detection threshold
// RULE21: detection suppressed for start-delay captures
// RULE22: flag set on event, irq when enabled
`timescale 1ns/1ps
`include "tkc_defs.vh"

module tkc_touch_ctrl #(
  parameter W = 24
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // oscillator sources and sleep input, sampled as synchronous levels
  input wire fast_internal_osc,
  input wire pll_clk,
  input wire rtc_clk,
  input wire slow_internal_osc,
  input wire sense_clock,
  input wire cpu_sleep,
  // axi4-lite write address
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // block outputs
  output reg irq,
  output reg high_speed_sel,
  output reg [6:0] analog_ctrl
);

  // -------------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------------
  reg controller_enable_reg;
  reg mode_reg;
  reg [1:0] internal_clock_select_reg;
  reg auto_reg;
  reg irq_enable_reg;
  reg irq_flag_reg;
  reg busy_reg;
  reg [7:0] afg_reg;
  reg [3:0] slow_filter_cfg_reg;
  reg [3:0] fast_filter_cfg_reg;
  reg [21:0] detect_threshold_reg;
  reg [1:0] detect_start_delay_reg;
  reg absolute_threshold_sel_reg;
  reg [W-1:0] timer_load_reg;
  reg [W-1:0] gate_timer_reg;
  reg [W-1:0] captured_count_reg;
  reg [W-1:0] captured_count_value_reg;
  reg [W-1:0] fast_average_reg;
  reg [W-1:0] slow_average_reg;
  reg [10:0] capture_num_reg;
  reg wake_reg;
  reg main_clk_d_reg;
  reg sense_d_reg;

  // -------------------------------------------------------------------------
  // clock selection and edge detection
  // -------------------------------------------------------------------------
  reg main_clk_src;
  always @* begin
    case (internal_clock_select_reg) // RULE4
      `TKC_CKS_FAST_INTERNAL_OSC: main_clk_src = fast_internal_osc;
      `TKC_CKS_PLL: main_clk_src = pll_clk;
      `TKC_CKS_RTC: main_clk_src = rtc_clk;
      default: main_clk_src = slow_internal_osc;
    endcase
  end

  // sleep stops every source but the slow oscillator
  wire main_alive = !cpu_sleep ||
    (internal_clock_select_reg == `TKC_CKS_SLOW_INTERNAL_OSC); // RULE18
  wire int_edge = main_clk_src && !main_clk_d_reg && main_alive;
  wire sense_edge = sense_clock && !sense_d_reg && main_alive;
  wire timer_tick = mode_reg ? int_edge : sense_edge; // RULE2 RULE3
  wire count_tick = mode_reg ? sense_edge : int_edge; // RULE2 RULE3

  // auto mode narrows the captured count, timer expiry compare and updated averages to 16 bits
  wire [W-1:0] vmask = auto_reg ? `TKC_AUTO_MASK : {W{1'b1}}; // RULE11
  wire timer_expire = busy_reg && timer_tick &&
    ((gate_timer_reg & vmask) == {W{1'b0}}); // RULE7

  // -------------------------------------------------------------------------
  // moving average filters
  // -------------------------------------------------------------------------
  wire [W-1:0] cap_val = captured_count_reg & vmask;
  reg [W+7:0] fast_new;
  reg [W+7:0] slow_new;
  always @* begin
    case (fast_filter_cfg_reg) // RULE19
      4'h1: fast_new = (({8'h00, fast_average_reg} << 1) -
        {8'h00, fast_average_reg} + {8'h00, cap_val}) >> 1;
      4'h2: fast_new = (({8'h00, fast_average_reg} << 2) -
        {8'h00, fast_average_reg} + {8'h00, cap_val}) >> 2;
      4'h3: fast_new = (({8'h00, fast_average_reg} << 3) -
        {8'h00, fast_average_reg} + {8'h00, cap_val}) >> 3;
      4'h4: fast_new = (({8'h00, fast_average_reg} << 4) -
        {8'h00, fast_average_reg} + {8'h00, cap_val}) >> 4;
      default: fast_new = {8'h00, cap_val};
    endcase
    case (slow_filter_cfg_reg) // RULE19
      4'h1: slow_new = (({8'h00, slow_average_reg} << 4) -
        {8'h00, slow_average_reg} + {8'h00, cap_val}) >> 4;
      4'h2: slow_new = (({8'h00, slow_average_reg} << 5) -
        {8'h00, slow_average_reg} + {8'h00, cap_val}) >> 5;
      4'h3: slow_new = (({8'h00, slow_average_reg} << 6) -
        {8'h00, slow_average_reg} + {8'h00, cap_val}) >> 6;
      4'h4: slow_new = (({8'h00, slow_average_reg} << 7) -
        {8'h00, slow_average_reg} + {8'h00, cap_val}) >> 7;
      default: slow_new = {8'h00, cap_val};
    endcase
  end
  wire [W-1:0] fast_upd = fast_new[W-1:0] & vmask; // RULE11
  wire [W-1:0] slow_upd = slow_new[W-1:0] & vmask;

  // -------------------------------------------------------------------------
  // wake detection on the freshly updated averages
  // -------------------------------------------------------------------------
  wire [W+9:0] ratio_prod = {10'h000, slow_upd} *
    {{W{1'b0}}, detect_threshold_reg[9:0]};
  wire [W+9:0] ratio_th = ratio_prod >> `TKC_RATIO_SHIFT;
  wire [W+9:0] threshold = absolute_threshold_sel_reg ?
    {{(W-12){1'b0}}, detect_threshold_reg} : ratio_th; // RULE20
  wire [W+9:0] diff = {10'h000, fast_upd} - {10'h000, slow_upd};
  reg [10:0] delay_need;
  always @* begin
    case (detect_start_delay_reg) // RULE21
      2'h0: delay_need = `TKC_DLY_CNT0;
      2'h1: delay_need = `TKC_DLY_CNT1;
      2'h2: delay_need = `TKC_DLY_CNT2;
      default: delay_need = `TKC_DLY_CNT3;
    endcase
  end
  wire delay_done = capture_num_reg >= delay_need; // RULE21
  wire detect = auto_reg && delay_done && (fast_upd > slow_upd) &&
    (diff > threshold); // RULE12

  // -------------------------------------------------------------------------
  // axi4-lite slave
  // -------------------------------------------------------------------------
  reg [31:0] awaddr_reg;
  reg aw_have_reg;
  reg [31:0] wdata_reg;
  reg w_have_reg;
  wire do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
  wire [15:0] widx = awaddr_reg[17:2];
  reg [3:0] wstrb_reg;
  wire wr_cfg = do_write && wstrb_reg != 4'h0 && widx == `TKC_IDX_CFG;
  wire start_cmd = wr_cfg && wdata_reg[`TKC_CFG_START]; // RULE13 RULE15
  wire abort_cmd = wr_cfg && !wdata_reg[`TKC_CFG_START]; // RULE14
  wire w_ok = widx == `TKC_IDX_CFG || widx == `TKC_IDX_AFG ||
    widx == `TKC_IDX_FFG || widx == `TKC_IDX_TH0 ||
    widx == `TKC_IDX_TH1 || widx == `TKC_IDX_TH2 ||
    widx == `TKC_IDX_TMR || widx == `TKC_IDX_MVF ||
    widx == `TKC_IDX_MVS;

  wire [15:0] ridx = s_axi_araddr[17:2];
  reg [31:0] rd_mux;
  reg rd_ok;
  always @* begin
    rd_ok = 1'b1;
    case (ridx)
      `TKC_IDX_CFG: rd_mux = {24'h000000, controller_enable_reg, mode_reg,
        internal_clock_select_reg, auto_reg, irq_enable_reg,
        irq_flag_reg, busy_reg}; // RULE15 RULE16
      `TKC_IDX_AFG: rd_mux = {24'h000000, afg_reg}; // RULE17
      `TKC_IDX_FFG: rd_mux = {24'h000000, slow_filter_cfg_reg,
        fast_filter_cfg_reg};
      `TKC_IDX_TH0: rd_mux = {24'h000000, detect_threshold_reg[7:0]};
      `TKC_IDX_TH1: rd_mux = {24'h000000, detect_threshold_reg[15:8]};
      `TKC_IDX_TH2: rd_mux = {24'h000000, absolute_threshold_sel_reg,
        detect_start_delay_reg[1:0], detect_threshold_reg[20:16]};
      `TKC_IDX_TMR: rd_mux = {8'h00, timer_load_reg};
      `TKC_IDX_VAL: rd_mux = {8'h00, captured_count_value_reg}; // RULE8
      `TKC_IDX_MVF: rd_mux = {8'h00, fast_average_reg};
      `TKC_IDX_MVS: rd_mux = {8'h00, slow_average_reg};
      `TKC_IDX_WAKE: rd_mux = {31'h00000000, wake_reg};
      default: begin
        rd_mux = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end

  // -------------------------------------------------------------------------
  // main sequential logic
  // -------------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TKC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `TKC_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      awaddr_reg <= 32'h00000000;
      aw_have_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      w_have_reg <= 1'b0;
      controller_enable_reg <= 1'b0;
      mode_reg <= 1'b0;
      internal_clock_select_reg <= `TKC_CKS_FAST_INTERNAL_OSC;
      auto_reg <= 1'b0;
      irq_enable_reg <= 1'b0;
      irq_flag_reg <= 1'b0;
      busy_reg <= 1'b0;
      afg_reg <= `TKC_CFG_RESET;
      slow_filter_cfg_reg <= 4'h0;
      fast_filter_cfg_reg <= 4'h0;
      detect_threshold_reg <= 22'h000000;
      detect_start_delay_reg <= 2'h0;
      absolute_threshold_sel_reg <= 1'b0;
      timer_load_reg <= {W{1'b0}};
      gate_timer_reg <= {W{1'b0}};
      captured_count_reg <= {W{1'b0}};
      captured_count_value_reg <= {W{1'b0}};
      fast_average_reg <= {W{1'b0}};
      slow_average_reg <= {W{1'b0}};
      capture_num_reg <= 11'h000;
      wake_reg <= 1'b0;
      main_clk_d_reg <= 1'b0;
      sense_d_reg <= 1'b0;
      irq <= 1'b0;
      high_speed_sel <= 1'b0;
      analog_ctrl <= 7'h00;
    end else begin
      main_clk_d_reg <= main_clk_src;
      sense_d_reg <= sense_clock;
      // address and data accepted in either order
      s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_reg <= s_axi_awaddr;
        aw_have_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        w_have_reg <= 1'b1;
      end
      if (do_write) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_ok ? `TKC_RESP_OKAY : `TKC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? `TKC_RESP_OKAY : `TKC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end

      // register writes; byte lane 0 only for byte registers
      if (do_write && wstrb_reg != 4'h0) begin
        case (widx)
          `TKC_IDX_CFG: begin
            controller_enable_reg <= wdata_reg[`TKC_CFG_EN]; // RULE16
            mode_reg <= wdata_reg[`TKC_CFG_MODE];
            internal_clock_select_reg <=
              wdata_reg[`TKC_CFG_CKS_HI:`TKC_CFG_CKS_LO];
            auto_reg <= wdata_reg[`TKC_CFG_AUTO];
            irq_enable_reg <= wdata_reg[`TKC_CFG_IEN];
          end
          `TKC_IDX_AFG: afg_reg <= wdata_reg[7:0]; // RULE17
          `TKC_IDX_FFG: begin
            slow_filter_cfg_reg <= wdata_reg[`TKC_SLOW_HI:`TKC_SLOW_LO];
            fast_filter_cfg_reg <= wdata_reg[`TKC_FAST_HI:0];
          end
          `TKC_IDX_TH0: detect_threshold_reg[7:0] <= wdata_reg[7:0];
          `TKC_IDX_TH1: detect_threshold_reg[15:8] <= wdata_reg[7:0];
          `TKC_IDX_TH2: begin
            absolute_threshold_sel_reg <= wdata_reg[`TKC_TH2_ABS];
            detect_start_delay_reg <= wdata_reg[`TKC_DLY_HI:`TKC_DLY_LO];
            detect_threshold_reg[21:16] <= {1'b0, wdata_reg[`TKC_THR_HI:0]};
          end
          `TKC_IDX_TMR: timer_load_reg <= wdata_reg[W-1:0];
          `TKC_IDX_MVF: fast_average_reg <= wdata_reg[W-1:0]; // RULE9
          `TKC_IDX_MVS: slow_average_reg <= wdata_reg[W-1:0]; // RULE9
          default: wake_reg <= wake_reg;
        endcase
      end
      high_speed_sel <= afg_reg[`TKC_AFG_HIGH_SPEED_SEL]; // RULE17
      analog_ctrl <= afg_reg[6:0];

      // capture engine
      if (start_cmd && wdata_reg[`TKC_CFG_EN]) begin
        busy_reg <= 1'b1;
        captured_count_reg <= {W{1'b0}}; // RULE5
        gate_timer_reg <= timer_load_reg; // RULE5
        capture_num_reg <= 11'h000;
        wake_reg <= 1'b0;
      end else if (abort_cmd || !controller_enable_reg) begin
        busy_reg <= 1'b0; // RULE14
      end else if (busy_reg) begin
        if (count_tick)
          captured_count_reg <= captured_count_reg + 1'b1; // RULE6
        if (timer_expire) begin
          captured_count_value_reg <= cap_val; // RULE7
          fast_average_reg <= fast_upd; // RULE8
          slow_average_reg <= slow_upd; // RULE8
          if (!delay_done)
            capture_num_reg <= capture_num_reg + 1'b1;
          if (auto_reg && !detect) begin
            captured_count_reg <= {W{1'b0}}; // RULE10
            gate_timer_reg <= timer_load_reg;
          end else begin
            busy_reg <= 1'b0; // RULE13
            wake_reg <= detect;
          end
        end else if (timer_tick) begin
          gate_timer_reg <= gate_timer_reg - 1'b1; // RULE1
        end
      end

      // any config write in the expiry cycle blocks the hardware set
      if (wr_cfg && !wdata_reg[`TKC_CFG_IFLAG])
        irq_flag_reg <= 1'b0;
      if (timer_expire && controller_enable_reg && !abort_cmd &&
          !start_cmd && (!auto_reg || detect))
        irq_flag_reg <= 1'b1; // RULE22 RULE10 RULE12
      irq <= irq_flag_reg && irq_enable_reg; // RULE22
    end
  end

endmodule // tkc_touch_ctrl

// [verification/tkc_sense_osc.sv]
`timescale 1ns/1ps
module tkc_sense_osc (
  // control
  input wire run,
  input wire [15:0] half_ns,
  // oscillator output
  output reg sense_clock
);
  // the key oscillator only swings while run is high
  initial begin
    sense_clock = 1'b0;
    forever begin
      if (run) #(half_ns) sense_clock <= ~sense_clock;
      else begin
        sense_clock <= 1'b0;
        @(run);
      end
    end
  end
endmodule // tkc_sense_osc

// [verification/tkc_touch_ctrl_sva.sv]
`timescale 1ns/1ps
`include "tkc_defs.vh"
module tkc_touch_ctrl_chk (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // bus
  input wire s_axi_awready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // block outputs
  input wire irq,
  input wire high_speed_sel,
  input wire [6:0] analog_ctrl
);
  reg [31:0] ra_reg;
  always @(posedge aclk) begin
    if (!aresetn) ra_reg <= 32'h0;
    else if (s_axi_arvalid && s_axi_arready) ra_reg <= s_axi_araddr;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_b_ans; s_axi_awready |-> ##[1:2] s_axi_bvalid; endproperty
  a_b_ans: assert property (p_b_ans) else $error("no write answer");
  property p_r_ans; s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_ans: assert property (p_r_ans) else $error("no read answer");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data moved");
  property p_cfg_byte;
    s_axi_rvalid && ra_reg == {14'h0, `TKC_IDX_CFG, 2'h0}
      |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_cfg_byte: assert property (p_cfg_byte) else $error("cfg upper bits");
  property p_irq_fall;
    $fell(irq) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
  property p_hs_chg;
    $changed(high_speed_sel) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2);
  endproperty
  a_hs_chg: assert property (p_hs_chg) else $error("speed bit moved");
  property p_ac_chg;
    $changed(analog_ctrl) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2);
  endproperty
  a_ac_chg: assert property (p_ac_chg) else $error("analog bits moved");
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `TKC_RESP_SLVERR);
  c_hs: cover property ($rose(high_speed_sel));
endmodule // tkc_touch_ctrl_chk
bind tkc_touch_ctrl tkc_touch_ctrl_chk i_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq),
  .high_speed_sel(high_speed_sel), .analog_ctrl(analog_ctrl));

// [verification/touch_key_capture_controller_test.sv]
`timescale 1ns/1ps
`include "tkc_defs.vh"
`define CHK(g, e) begin total_checks = total_checks + 1; if ((g) !== (e)) \
  begin fails = fails + 1; \
  $display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end
module touch_key_capture_controller_test;
  reg aclk;
  reg aresetn = 1'b0;
  reg [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  reg arvalid = 1'b0, rready = 1'b0, sleep = 1'b0, srun = 1'b0;
  reg [3:0] src_run = 4'h0;
  reg [3:0] wstrb = 4'hF;
  reg [2:0] div = 3'h0;
  reg [15:0] half = 16'h0193;
  wire awready, wready, bvalid, arready, rvalid, irq, hss, sense_clock;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [6:0] actl;
  wire [3:0] src = src_run & {4{div[2]}};
  integer fails = 0, total_checks = 0, k;
  reg [31:0] d, v;
  reg [1:0] r;
  tkc_touch_ctrl i_dut (.aclk(aclk), .aresetn(aresetn),
    .fast_internal_osc(src[0]), .pll_clk(src[1]), .rtc_clk(src[2]),
    .slow_internal_osc(src[3]), .sense_clock(sense_clock), .cpu_sleep(sleep),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq),
    .high_speed_sel(hss), .analog_ctrl(actl));
  tkc_sense_osc i_osc (.run(srun), .half_ns(half), .sense_clock(sense_clock));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) div <= div + 3'h1;
  // ---------------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------------
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task hang;
    begin
      fails = fails + 1;
      tally_and_finish;
    end
  endtask
  task axi_wr(input [15:0] i, input [31:0] dat, output [1:0] resp);
    integer n;
    begin
      @(posedge aclk);
      awaddr <= {14'h0, i, 2'h0};
      wdata <= dat;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 64 && bvalid !== 1'b1; n = n + 1) begin
        @(posedge aclk);
        if (awready === 1'b1) awvalid <= 1'b0;
        if (wready === 1'b1) wvalid <= 1'b0;
      end
      resp = bresp;
      bready <= 1'b0;
      if (n == 64) hang;
    end
  endtask
  task axi_rd(input [15:0] i, output [31:0] dat, output [1:0] resp);
    integer n;
    begin
      @(posedge aclk);
      araddr <= {14'h0, i, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 64 && rvalid !== 1'b1; n = n + 1) begin
        @(posedge aclk);
        if (arready === 1'b1) arvalid <= 1'b0;
      end
      dat = rdata;
      resp = rresp;
      rready <= 1'b0;
      if (n == 64) hang;
    end
  endtask
  task wr(input [15:0] i, input [31:0] dat);
    begin
      axi_wr(i, dat, r);
      `CHK(r, `TKC_RESP_OKAY)
    end
  endtask
  task wait_idle;
    integer n;
    begin
      d = 32'h1;
      for (n = 0; n < 400 && d[0] !== 1'b0; n = n + 1) axi_rd(`TKC_IDX_CFG, d, r);
      if (n == 400) hang;
    end
  endtask
  // ---------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------
  task t_regs;
    begin
      axi_rd(`TKC_IDX_CFG, d, r);
      `CHK(d, 32'h0)
      axi_rd(`TKC_IDX_AFG, d, r);
      `CHK(d, 32'h0)
      axi_rd(16'hA13F, d, r);
      `CHK(r, `TKC_RESP_SLVERR)
      axi_wr(16'hA13F, 32'hFF, r);
      `CHK(r, `TKC_RESP_SLVERR)
      wr(`TKC_IDX_AFG, 32'hD5);
      axi_rd(`TKC_IDX_AFG, d, r);
      `CHK(d, 32'hD5)
      @(posedge aclk);
      #1 `CHK({hss, actl}, 8'hD5)
      wr(`TKC_IDX_AFG, 32'h2A);
      @(posedge aclk);
      #1 `CHK({hss, actl}, 8'h2A)
      wstrb <= 4'h0;
      wr(`TKC_IDX_AFG, 32'h55);
      wstrb <= 4'hF;
      axi_rd(`TKC_IDX_AFG, d, r);
      `CHK(d, 32'h2A)
      wr(`TKC_IDX_TH2, 32'hFF);
      axi_rd(`TKC_IDX_TH2, d, r);
      `CHK(d, 32'hFF)
    end
  endtask
  task t_cap(input m, input [1:0] cks, input [23:0] t, input [31:0] lo,
    input [31:0] hi);
    begin
      src_run <= 4'h1 << cks;
      wr(`TKC_IDX_FFG, 32'h11);
      srun <= 1'b1;
      wr(`TKC_IDX_MVF, 32'h64);
      wr(`TKC_IDX_MVS, 32'hC8);
      wr(`TKC_IDX_TMR, {8'h0, t});
      wr(`TKC_IDX_CFG, {24'h0, 2'h2 | m, cks, 4'h5});
      axi_rd(`TKC_IDX_CFG, d, r);
      `CHK(d[0], 1'b1)
      wait_idle;
      `CHK(d[1], 1'b1)
      `CHK(irq, 1'b1)
      axi_rd(`TKC_IDX_VAL, v, r);
      `CHK(v >= lo && v <= hi, 1'b1)
      axi_rd(`TKC_IDX_MVF, d, r);
      `CHK(d, (32'h64 + v) >> 1)
      axi_rd(`TKC_IDX_MVS, d, r);
      `CHK(d, (32'hC8 * 32'hF + v) >> 4)
      wr(`TKC_IDX_CFG, 32'h84);
      @(posedge aclk);
      #1 `CHK(irq, 1'b0)
      srun <= 1'b0;
    end
  endtask
  task t_abort;
    begin
      wr(`TKC_IDX_TMR, 32'hFFFF);
      srun <= 1'b1;
      wr(`TKC_IDX_CFG, 32'h85);
      axi_rd(`TKC_IDX_CFG, d, r);
      `CHK(d[0], 1'b1)
      wr(`TKC_IDX_CFG, 32'h84);
      axi_rd(`TKC_IDX_CFG, d, r);
      `CHK(d[1:0], 2'h0)
      srun <= 1'b0;
    end
  endtask
  task t_auto;
    integer n, hits;
    begin
      half <= 16'h07D3;
      src_run <= 4'h8;
      sleep <= 1'b1;
      wr(`TKC_IDX_MVF, 32'h8);
      srun <= 1'b1;
      wr(`TKC_IDX_MVS, 32'h8);
      wr(`TKC_IDX_FFG, 32'h40);
      wr(`TKC_IDX_TH0, 32'h5);
      wr(`TKC_IDX_TH1, 32'h0);
      wr(`TKC_IDX_TH2, 32'h80);
      wr(`TKC_IDX_TMR, 32'h1);
      wr(`TKC_IDX_CFG, 32'hBD);
      hits = 0;
      for (n = 0; n < 11000; n = n + 1) begin
        @(posedge aclk);
        if (irq !== 1'b0) hits = hits + 1;
      end
      `CHK(hits, 0)
      for (n = 0; n < 40000 && irq !== 1'b1; n = n + 1) @(posedge aclk);
      if (n == 40000) hang;
      `CHK(irq, 1'b1)
      axi_rd(`TKC_IDX_WAKE, d, r);
      `CHK(d[0], 1'b1)
      axi_rd(`TKC_IDX_CFG, d, r);
      `CHK(d[0], 1'b0)
      axi_rd(`TKC_IDX_VAL, d, r);
      `CHK(d[31:16], 16'h0)
    end
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    for (k = 0; k < 4; k = k + 1) t_cap(1'b0, k[1:0], 24'h3, 14, 22);
    t_cap(1'b1, 2'h0, 24'h13, 3, 5);
    t_abort;
    t_auto;
    tally_and_finish;
  end
endmodule // touch_key_capture_controller_test
